// ==== rtl/tig_pkg.sv ====
// Constants and types for the identification carrier pattern generator.
// Assumes one elementary-period tick per sample strobe and the 1536-carrier mode.
package tig_pkg;

    // =====================================================================
    // Timing
    // =====================================================================
    localparam longint EP_RATE_HZ = 2048000;
    localparam longint FRAME_TIME_US = 96000;
    localparam int FRAME_EP = int'(FRAME_TIME_US * EP_RATE_HZ / 64'd1000000);
    localparam int SYNC_EP = 5208;
    localparam int CLK_PERIOD_NS = 50;
    localparam int TICK_W = 18;

    // =====================================================================
    // Carrier layout
    // =====================================================================
    localparam int IDX_W = 11;
    localparam int BAND0_OFF = -768;
    localparam int BAND1_OFF = -384;
    localparam int BAND2_OFF = 1;
    localparam int BAND3_OFF = 385;
    localparam int BAND_SPAN = 384;
    localparam int COMB_STEP = 2;
    localparam int PAIR_STEP = 48;
    localparam int PAIRS = 8;
    localparam int PAIRS_ON = 4;

    // =====================================================================
    // Selection numbers and data widths
    // =====================================================================
    localparam int PAT_W = 7;
    localparam int COMB_W = 5;
    localparam int PATTERN_MAX = 69;
    localparam int COMB_MAX = 23;
    localparam int IFC_W = 13;
    localparam int IDENT_PHASE_BIT = 2;
    localparam int PH_W = 16;
    localparam int OUT_W = 17;

    typedef logic [PAIRS-1:0] tig_pair_mask_t;

    // True when carrier k is a switched-on base carrier for comb c and mask en
    function automatic logic tig_base_on(input logic signed [IDX_W-1:0] k, input logic [COMB_W-1:0] c,
                                         input tig_pair_mask_t en);
        int off;
        int d;
        int b;
        logic hit;
        off = 0;
        hit = 1'b1;
        if (int'(k) >= BAND0_OFF && int'(k) < BAND1_OFF)
            off = BAND0_OFF;
        else if (int'(k) >= BAND1_OFF && int'(k) < 0)
            off = BAND1_OFF;
        else if (int'(k) > 0 && int'(k) <= BAND_SPAN)
            off = BAND2_OFF;
        else if (int'(k) > BAND_SPAN && int'(k) <= 2 * BAND_SPAN)
            off = BAND3_OFF;
        else
            hit = 1'b0;
        d = int'(k) - off - COMB_STEP * int'(c);
        b = d / PAIR_STEP;
        if (d < 0 || (d % PAIR_STEP) != 0 || b >= PAIRS)
            hit = 1'b0;
        if (hit)
            hit = en[PAIRS - 1 - (b % PAIRS)];
        return hit;
    endfunction

endpackage

// ==== rtl/tig_pattern_rom.sv ====
// Pattern number to pair-enable mask lookup.
// Assumes the caller range-checks the pattern number; out of range gives zero.
`timescale 1ns/1ns
module tig_pattern_rom
    import tig_pkg::*;
(
    // Lookup
    input wire logic [PAT_W-1:0] pattern,
    output tig_pair_mask_t mask
);

    // =====================================================================
    // Ascending four-of-eight words, b=0 in the MSB
    // =====================================================================
    function automatic tig_pair_mask_t nth_word(input int n);
        tig_pair_mask_t w;
        int seen;
        w = '0;
        seen = 0;
        for (int v = 0; v < 256; v++)
        begin
            if ($countones(v[PAIRS-1:0]) == PAIRS_ON)
            begin
                if (seen == n)
                    w = v[PAIRS-1:0];
                seen = seen + 1;
            end
        end
        return w;
    endfunction

    always_comb
    begin
        mask = '0;
        if (int'(pattern) <= PATTERN_MAX)
            mask = nth_word(int'(pattern));
    end

endmodule // tig_pattern_rom

// ==== rtl/tig_ident_gen.sv ====
// Identification null-symbol carrier generator with frame timing.
// Assumes SAMPLE_TICK marks one elementary period and the phase table answers combinationally.
`timescale 1ns/1ns
module tig_ident_gen
    import tig_pkg::*;
#(
    parameter int FRAME_TICKS = FRAME_EP,
    parameter int SYNC_TICKS = SYNC_EP
)
(
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RST_N,
    // Timing
    input wire logic SAMPLE_TICK,
    output logic FRAME_START,
    output logic SYNC_ACTIVE,
    output logic IDENT_FRAME,
    // Configuration
    input wire logic [PAT_W-1:0] PATTERN_SELECT_NUMBER,
    input wire logic [COMB_W-1:0] COMB_SELECT_NUMBER,
    input wire logic [IFC_W-1:0] INTERLEAVED_FRAME_COUNT,
    output logic CFG_ERROR,
    // Carrier requests
    input wire logic CARR_REQ,
    input wire logic signed [IDX_W-1:0] CARR_INDEX,
    output logic CARR_VALID,
    output logic signed [OUT_W-1:0] CARR_RE,
    output logic signed [OUT_W-1:0] CARR_IM,
    // Phase table
    output logic signed [IDX_W-1:0] PHASE_ADDR,
    input wire logic signed [PH_W-1:0] PHASE_RE,
    input wire logic signed [PH_W-1:0] PHASE_IM
);

    typedef struct packed {
        logic [TICK_W-1:0] tick;
        logic frame_start;
        logic sync_active;
        logic ident_on;
        logic cfg_error;
        tig_pair_mask_t en;
        logic [COMB_W-1:0] comb;
        logic prev_valid;
        logic prev_on;
        logic signed [IDX_W-1:0] prev_index;
        logic signed [PH_W-1:0] prev_re;
        logic signed [PH_W-1:0] prev_im;
        logic own_on;
        logic lo_on;
        logic out_valid;
        logic signed [OUT_W-1:0] out_re;
        logic signed [OUT_W-1:0] out_im;
    } tig_state_s;

    tig_state_s s;
    tig_state_s next_s;
    tig_pair_mask_t pat_mask;
    logic cfg_ok;
    logic own;
    logic lo;

    // =====================================================================
    // Pattern lookup
    // =====================================================================
    tig_pattern_rom u_rom (
        .pattern(PATTERN_SELECT_NUMBER),
        .mask(pat_mask)
    );

    // Undefined selections send nothing rather than a guessed pattern
    assign cfg_ok = (int'(PATTERN_SELECT_NUMBER) <= PATTERN_MAX) && (int'(COMB_SELECT_NUMBER) <= COMB_MAX);

    // Table addressed straight from the request, answer used in the same cycle
    assign PHASE_ADDR = CARR_INDEX;

    // =====================================================================
    // Next state
    // =====================================================================
    always_comb
    begin
        next_s = s;
        next_s.frame_start = 1'b0;
        next_s.cfg_error = ~cfg_ok;
        own = 1'b0;
        lo = 1'b0;
        if (SAMPLE_TICK)
        begin
            if (int'(s.tick) == FRAME_TICKS - 1)
            begin
                next_s.tick = '0;
                next_s.frame_start = 1'b1;
                next_s.ident_on = ~INTERLEAVED_FRAME_COUNT[IDENT_PHASE_BIT] & cfg_ok;
                next_s.en = pat_mask;
                next_s.comb = COMB_SELECT_NUMBER;
                next_s.prev_valid = 1'b0;
            end
            else
            begin
                next_s.tick = s.tick + 1'b1;
            end
        end
        next_s.sync_active = int'(next_s.tick) < SYNC_TICKS;
        next_s.out_valid = CARR_REQ;
        if (CARR_REQ)
        begin
            // Base test uses the settings latched for the whole frame
            own = s.ident_on & tig_base_on(CARR_INDEX, s.comb, s.en);
            // Upper carrier of a pair relies on the previous request being k-1
            lo = s.ident_on & s.prev_valid & s.prev_on & (int'(CARR_INDEX) == int'(s.prev_index) + 1);
            next_s.own_on = own;
            next_s.lo_on = lo;
            next_s.out_re = (own ? OUT_W'(PHASE_RE) : '0) + (lo ? OUT_W'(s.prev_re) : '0);
            next_s.out_im = (own ? OUT_W'(PHASE_IM) : '0) + (lo ? OUT_W'(s.prev_im) : '0);
            next_s.prev_valid = 1'b1;
            next_s.prev_on = own;
            next_s.prev_index = CARR_INDEX;
            next_s.prev_re = PHASE_RE;
            next_s.prev_im = PHASE_IM;
        end
    end

    // =====================================================================
    // State register
    // =====================================================================
    always_ff @(posedge CLK_SYS)
    begin
        if (!RST_N)
        begin
            s <= '0;
            s.sync_active <= 1'b1;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign FRAME_START = s.frame_start;
    assign SYNC_ACTIVE = s.sync_active;
    assign IDENT_FRAME = s.ident_on;
    assign CFG_ERROR = s.cfg_error;
    assign CARR_VALID = s.out_valid;
    assign CARR_RE = s.out_re;
    assign CARR_IM = s.out_im;

    // =====================================================================
    // Checks
    // =====================================================================
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RST_N);

    a_ident_gate: assert property (
        s.frame_start |-> s.ident_on == (!$past(INTERLEAVED_FRAME_COUNT[IDENT_PHASE_BIT]) && $past(cfg_ok)))
        else $error("identification gate does not follow frame count");

    // An answer landing on the wrap edge still carries the old frame's setting
    a_zero_off: assert property (
        (s.out_valid && !s.ident_on && !s.frame_start) |-> (s.out_re == 0 && s.out_im == 0))
        else $error("nonzero carrier outside identification frame");

    a_quiet_pairs: assert property (
        (!s.ident_on && !s.frame_start && s.out_valid) |-> (!s.own_on && !s.lo_on))
        else $error("carrier switched on outside identification frame");

    a_pair_upper: assert property (
        (CARR_REQ && s.ident_on && s.prev_valid && s.prev_on && int'(CARR_INDEX) == int'(s.prev_index) + 1)
        |=> (s.lo_on && s.out_re == $past(OUT_W'(s.prev_re)) + (s.own_on ? OUT_W'($past(PHASE_RE)) : OUT_W'(0))))
        else $error("upper carrier of pair lacks lower phase");

    a_never_base: assert property (
        (CARR_REQ && (int'(CARR_INDEX) == 0 || int'(CARR_INDEX) == -769)) |=> !s.own_on)
        else $error("carrier 0 or -769 used as base");

    a_mask_weight: assert property (
        (s.frame_start && !s.cfg_error && s.ident_on) |-> $countones(s.en) == PAIRS_ON)
        else $error("pattern mask does not hold four pairs");

    a_bad_cfg: assert property (
        (s.frame_start && $past(!cfg_ok)) |-> !s.ident_on ##1 !s.ident_on)
        else $error("undefined selection produced identification");

    a_frame_len: assert property (
        int'(s.tick) < FRAME_TICKS)
        else $error("frame counter beyond frame length");

    a_sync_start: assert property (
        s.frame_start |-> s.sync_active ##1 s.sync_active)
        else $error("frame does not open with sync channel");

    a_tick_hold: assert property (
        !SAMPLE_TICK |=> $stable(s.tick))
        else $error("frame timing moved without a sample tick");

    a_own_phase: assert property (
        (CARR_REQ && s.ident_on && tig_base_on(CARR_INDEX, s.comb, s.en) && !s.prev_on)
        |=> (s.out_re == OUT_W'($past(PHASE_RE)) && s.out_im == OUT_W'($past(PHASE_IM))))
        else $error("base carrier value differs from table phase");

    a_start_pulse: assert property (
        s.frame_start |=> !s.frame_start)
        else $error("frame start longer than one cycle");

    a_start_wrap: assert property (
        s.frame_start |-> s.tick == '0)
        else $error("frame start away from counter wrap");

    a_sync_window: assert property (
        s.sync_active == (int'(s.tick) < SYNC_TICKS))
        else $error("sync window disagrees with frame counter");

    a_valid_follow: assert property (
        s.out_valid == $past(CARR_REQ))
        else $error("carrier answer not one cycle after request");

    a_addr_follow: assert property (
        PHASE_ADDR == CARR_INDEX)
        else $error("phase table address differs from request");

    a_cfg_flag: assert property (
        s.cfg_error == !$past(cfg_ok))
        else $error("configuration flag disagrees with selection");

    // Lookup checked live so a bad table entry shows before any frame uses it
    a_rom_weight: assert property (
        (int'(PATTERN_SELECT_NUMBER) <= PATTERN_MAX) |-> $countones(pat_mask) == PAIRS_ON)
        else $error("pattern word does not hold four pairs");

    a_rom_first: assert property (
        (PATTERN_SELECT_NUMBER == 7'h00) |-> pat_mask == 8'h0f)
        else $error("first pattern word wrong");

    a_rom_last: assert property (
        (int'(PATTERN_SELECT_NUMBER) == PATTERN_MAX) |-> pat_mask == 8'hf0)
        else $error("last pattern word wrong");

    a_rom_range: assert property (
        (int'(PATTERN_SELECT_NUMBER) > PATTERN_MAX) |-> pat_mask == '0)
        else $error("undefined pattern gives a mask");

    c_ident_frame: cover property (s.frame_start && s.ident_on);
    c_quiet_frame: cover property (s.frame_start && !s.ident_on);
    c_pair_out: cover property (s.out_valid && s.own_on ##1 s.out_valid && s.lo_on);
    c_bad_cfg: cover property (s.cfg_error ##1 s.frame_start);

endmodule // tig_ident_gen

// ==== dv/tig_phase_model.sv ====
// Reference phase table model for the identification generator.
// Assumes the generator reads it combinationally in the request cycle.
`timescale 1ns/1ns
module tig_phase_model
    import tig_pkg::*;
(
    // Lookup
    input wire logic signed [IDX_W-1:0] addr,
    output logic signed [PH_W-1:0] re,
    output logic signed [PH_W-1:0] im
);
    // ====================
    // Table
    // ====================
    // Distinct, never-zero values so a wrong address or a lost neighbour shows
    assign re = PH_W'(addr * 7 + 100);
    assign im = PH_W'(-addr * 5 - 3);
endmodule // tig_phase_model

// ==== dv/tig_ident_gen_tb.sv ====
// Self-checking bench for the identification carrier generator.
// Assumes short frames (64 ticks, 8 sync ticks) and the phase table model.
`timescale 1ns/1ns
module tig_ident_gen_tb;
    import tig_pkg::*;
    localparam int FT = 64;
    localparam int ST = 8;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic sample_tick = 1'b1;
    logic [PAT_W-1:0] pat = '0;
    logic [COMB_W-1:0] comb = '0;
    logic [IFC_W-1:0] ifc = '0;
    logic carr_req = 1'b0;
    logic signed [IDX_W-1:0] carr_index = '0;
    logic frame_start, sync_active, ident_frame, cfg_error, carr_valid;
    logic signed [OUT_W-1:0] carr_re, carr_im;
    logic signed [IDX_W-1:0] phase_addr;
    logic signed [PH_W-1:0] phase_re, phase_im;
    int errors = 0;
    int tests_run = 0;

    tig_ident_gen #(.FRAME_TICKS(FT), .SYNC_TICKS(ST)) dut (.CLK_SYS(clk_sys), .RST_N(rst_n),
        .SAMPLE_TICK(sample_tick), .FRAME_START(frame_start), .SYNC_ACTIVE(sync_active),
        .IDENT_FRAME(ident_frame), .PATTERN_SELECT_NUMBER(pat), .COMB_SELECT_NUMBER(comb),
        .INTERLEAVED_FRAME_COUNT(ifc), .CFG_ERROR(cfg_error), .CARR_REQ(carr_req),
        .CARR_INDEX(carr_index), .CARR_VALID(carr_valid), .CARR_RE(carr_re), .CARR_IM(carr_im),
        .PHASE_ADDR(phase_addr), .PHASE_RE(phase_re), .PHASE_IM(phase_im));
    tig_phase_model u_phase (.addr(phase_addr), .re(phase_re), .im(phase_im));

    initial
    begin
        forever #25 clk_sys = ~clk_sys;
    end

    // ====================
    // Expectations
    // ====================
    function automatic bit base_on(input int k, input int c, input int p);
        int off;
        int d;
        int n;
        logic [7:0] w;
        n = 0;
        w = 8'h00;
        for (int v = 0; v < 256; v++)
            if ($countones(v[7:0]) == 4 && n++ == p)
                w = v[7:0];
        off = (k < -384) ? -768 : (k < 0) ? -384 : (k <= 384) ? 1 : 385;
        d = k - off - 2 * c;
        if (k < -768 || d < 0 || d % 48 != 0 || d / 48 > 7)
            return 1'b0;
        return w[7 - d / 48];
    endfunction

    function automatic logic [OUT_W-1:0] exp_val(input int k, input int c, input int p, input bit on,
                                                 input bit im);
        int v;
        v = 0;
        if (on && base_on(k, c, p))
            v += im ? -k * 5 - 3 : k * 7 + 100;
        if (on && base_on(k - 1, c, p))
            v += im ? -(k - 1) * 5 - 3 : (k - 1) * 7 + 100;
        return OUT_W'(v);
    endfunction

    // ====================
    // Shared tasks
    // ====================
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input logic [OUT_W-1:0] got, input logic [OUT_W-1:0] want, input string what);
        tests_run++;
        if (got !== want)
        begin
            errors++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, want);
        end
    endtask

    task automatic wait_frame();
        for (int i = 0; i < 300; i++)
        begin
            @(posedge clk_sys);
            #1;
            if (frame_start === 1'b1)
                return;
        end
        errors++;
        $display("unexpected at %0t: no frame start", $time);
        tally_and_finish();
    endtask

    // Settings take effect at the next frame wrap, so one whole frame is spent
    task automatic setup(input int p, input int c, input int cnt);
        wait_frame();
        pat <= PAT_W'(p);
        comb <= COMB_W'(c);
        ifc <= IFC_W'(cnt);
        wait_frame();
    endtask

    // Ticks are held off so the frame setting cannot change under the sweep
    task automatic sweep(input int p, input int c, input bit on);
        int nz;
        nz = 0;
        @(posedge clk_sys);
        sample_tick <= 1'b0;
        for (int k = -768; k <= 769; k++)
        begin
            @(posedge clk_sys);
            carr_req <= (k <= 768);
            carr_index <= IDX_W'(k);
            #1;
            if (k > -768)
            begin
                check(carr_valid, 1, "valid");
                check(carr_re, exp_val(k - 1, c, p, on, 0), "real");
                check(carr_im, exp_val(k - 1, c, p, on, 1), "imag");
                nz += (carr_re != 0);
            end
        end
        @(posedge clk_sys);
        #1;
        check(carr_valid, 0, "valid pulse");
        check(nz, on ? 32 : 0, "active carriers");
        sample_tick <= 1'b1;
    endtask

    // ====================
    // Scenarios
    // ====================
    task automatic t_timing();
        int n;
        int s;
        wait_frame();
        n = 0;
        s = sync_active;
        while (n < 200)
        begin
            @(posedge clk_sys);
            #1;
            n++;
            if (frame_start === 1'b1)
                break;
            s += sync_active;
        end
        check(n, FT, "frame length");
        check(s, ST, "sync length");
        $display("done timing");
    endtask

    task automatic t_count();
        for (int i = 0; i < 8; i++)
        begin
            setup(11, 1, 16 + i);
            check(ident_frame, i < 4, "ident frame");
        end
        $display("done frame count");
    endtask

    task automatic t_patterns();
        setup(0, 0, 0);
        sweep(0, 0, 1);
        setup(69, 23, 1);
        sweep(69, 23, 1);
        setup(11, 1, 3);
        sweep(11, 1, 1);
        setup(11, 1, 4);
        sweep(11, 1, 0);
        $display("done patterns");
    endtask

    task automatic t_bad_cfg();
        setup(70, 0, 0);
        check(cfg_error, 1, "pattern range");
        check(ident_frame, 0, "bad pattern frame");
        sweep(70, 0, 0);
        setup(0, 24, 0);
        check(cfg_error, 1, "comb range");
        setup(0, 0, 0);
        check(cfg_error, 0, "config ok");
        $display("done bad config");
    endtask

    initial
    begin
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_timing();
        t_count();
        t_patterns();
        t_bad_cfg();
        tally_and_finish();
    end
endmodule // tig_ident_gen_tb
